// File: src/eewp_top.sv
`timescale 1ns/1ps
module eewp_top #(
  parameter int ADDR_W        = 10,        // array address width, 10 for 1k bytes
  parameter int WRITE_TIME_NS = 5000000    // internal write cycle time
) (
  input  wire logic                      sys_clk,            // system clock
  input  wire logic                      rst,                // power-up reset, async high
  input  wire logic                      clk_en,             // freezes core state while low
  input  wire logic                      spi_clk,            // serial clock from the host
  input  wire logic                      cs_n,               // chip select pin, low active
  input  wire logic                      si,                 // serial data in pin
  input  wire logic                      wp_n,               // write-protect pin, low active
  output logic                           so_out,             // serial data out level
  output logic                           so_oe,              // high while so is driven
  output logic                           write_enable_latch, // volatile write enable
  output logic                           write_busy_flag,    // internal write in progress
  output logic                           pin_protect_enable, // nonvolatile pin enable
  output logic                           block_protect_hi,   // nonvolatile protect bit 1
  output logic                           block_protect_lo,   // nonvolatile protect bit 0
  output logic                           hw_protect_active,  // pin protection in force
  output logic [eewp_pkg::SR_W-1:0]      status_word,        // status byte as read
  output logic                           array_write_start,  // pulse: program the array
  output logic [ADDR_W-1:0]              array_write_addr    // start address of that write
);
  import eewp_pkg::*;

  localparam int WRITE_CYCLES = (WRITE_TIME_NS / CLK_PERIOD_NS < 1) ? 1 : WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int PCNT_W       = $clog2(WRITE_CYCLES + 1);
  localparam logic [PCNT_W-1:0] PCNT_LAST = PCNT_W'(WRITE_CYCLES - 1);

  eewp_frame_if frame ();

  logic        cs_meta;
  logic        cs_sync;
  logic        cs_prev;
  logic        wp_meta;
  logic        wp_sync;
  logic        armed;
  logic        frame_end;
  logic        cs_fall;
  logic        go;
  logic        latch_set_ok;
  logic        latch_clr_ok;
  logic        status_wr_ok;
  logic        array_wr_ok;
  logic        status_accept;
  logic        array_accept;
  logic        hw_prot;
  logic [1:0]  block_code;
  logic        prog_done;
  logic [PCNT_W-1:0] prog_cnt;
  eewp_state_t state;

  // true when the address falls in a segment selected by the protect code
  function automatic logic is_protected(input logic [1:0] code, input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b1;
    case (code)
      PROT_NONE:    hit = 1'b0;
      PROT_QUARTER: hit = &a[ADDR_W-1 -: 2];
      PROT_HALF:    hit = a[ADDR_W-1];
      default:      hit = 1'b1;
    endcase
    return hit;
  endfunction

  eewp_link u_link (
    .spi_clk   (spi_clk),
    .rst       (rst),
    .cs_n      (cs_n),
    .si        (si),
    .status_in (status_word),
    .so_out    (so_out),
    .so_oe     (so_oe),
    .frame     (frame.link)
  );

  // pins cross into the core domain through two flops; idle select reads as high
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end
    else if (clk_en)
    begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      wp_meta <= wp_n;
      wp_sync <= wp_meta;
    end
  end

  // frame words are stable here because the host keeps the serial clock still while deselected
  assign frame_end  = cs_sync & ~cs_prev;
  assign cs_fall    = ~cs_sync & cs_prev;
  assign block_code = {block_protect_hi, block_protect_lo};
  assign prog_done  = (state == EEWP_PROGRAM) && (prog_cnt == PCNT_LAST);  // last timer cycle, never while idle
  assign hw_prot    = pin_protect_enable & ~wp_sync;
  assign go         = clk_en & frame_end & armed & (state == EEWP_IDLE);

  // length checks: latch and status writes need the exact edge count, array writes whole bytes from 32 edges up
  assign latch_set_ok = (frame.op == LATCH_SET_CMD) && (frame.nbits == CMD_BITS);
  assign latch_clr_ok = (frame.op == LATCH_CLEAR_CMD) && (frame.nbits == CMD_BITS);
  assign status_wr_ok = (frame.op == STATUS_WRITE_CMD) && (frame.nbits == STATUS_WRITE_BITS);
  assign array_wr_ok  = (frame.op == ARRAY_WRITE_CMD) && (frame.nbits >= MIN_WRITE_BITS)
                        && (frame.nbits[2:0] == 3'h0) && (frame.nbits != BIT_CNT_MAX);

  // a write needs the latch; hardware protection only stops status writes
  assign status_accept = go & status_wr_ok & write_enable_latch & ~hw_prot;
  assign array_accept  = go & array_wr_ok & write_enable_latch
                         & ~is_protected(block_code, frame.addr[ADDR_W-1:0]);

  // nothing executes until a select fall is seen after power-up
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      armed <= 1'b0;
    else if (clk_en && cs_fall)
      armed <= 1'b1;
  end

  // internal write cycle timer; select edges are ignored until it ends
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state           <= EEWP_IDLE;
      prog_cnt        <= '0;
      write_busy_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state)
        EEWP_IDLE:
        begin
          prog_cnt <= '0;
          if (status_accept || array_accept)
          begin
            state           <= EEWP_PROGRAM;
            write_busy_flag <= 1'b1;
          end
        end
        EEWP_PROGRAM:
        begin
          if (prog_cnt == PCNT_LAST)
          begin
            state           <= EEWP_IDLE;
            write_busy_flag <= 1'b0;
          end
          else
            prog_cnt <= prog_cnt + 1'b1;
        end
        default:
        begin
          state           <= EEWP_IDLE;
          write_busy_flag <= 1'b0;
        end
      endcase
    end
  end

  // write enable latch: commands work whatever the protection state
  // clearing on the edge that drops busy keeps a latch command from colliding with the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      write_enable_latch <= LATCH_RST;
    else if (clk_en)
    begin
      if (prog_done)
        write_enable_latch <= 1'b0;
      else if (go && latch_set_ok)
        write_enable_latch <= 1'b1;
      else if (go && latch_clr_ok)
        write_enable_latch <= 1'b0;
    end
  end

  // nonvolatile bits change only through an accepted status write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_protect_enable <= PIN_PROTECT_RST;
      block_protect_hi   <= BLOCK_PROTECT_RST[1];
      block_protect_lo   <= BLOCK_PROTECT_RST[0];
    end
    else if (clk_en && status_accept)
    begin
      pin_protect_enable <= frame.sdata[SR_PIN_PROTECT_BIT];
      block_protect_hi   <= frame.sdata[SR_BLOCK_HI_BIT];
      block_protect_lo   <= frame.sdata[SR_BLOCK_LO_BIT];
    end
  end

  // array program request toward the storage; data bytes are handled elsewhere
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      array_write_start <= 1'b0;
      array_write_addr  <= '0;
    end
    else if (clk_en)
    begin
      array_write_start <= array_accept;
      if (array_accept)
        array_write_addr <= frame.addr[ADDR_W-1:0];
    end
  end

  // readable status, unused bits as zero; registered so the link sees a clean level
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      status_word       <= '0;
      hw_protect_active <= 1'b0;
    end
    else if (clk_en)
    begin
      status_word                     <= '0;
      status_word[SR_PIN_PROTECT_BIT] <= pin_protect_enable;
      status_word[SR_BLOCK_HI_BIT]    <= block_protect_hi;
      status_word[SR_BLOCK_LO_BIT]    <= block_protect_lo;
      status_word[SR_LATCH_BIT]       <= write_enable_latch;
      status_word[SR_BUSY_BIT]        <= write_busy_flag;
      hw_protect_active               <= hw_prot;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_nv_change_cause;
    (clk_en && (frame_end && armed && state == EEWP_IDLE) && !(write_enable_latch && !hw_prot)) |=>
      $stable({pin_protect_enable, block_protect_hi, block_protect_lo});
  endproperty
  a_nv_change_cause: assert property (p_nv_change_cause) else $error("protect bits changed without permission");

  property p_hw_blocks_status;
    (go && status_wr_ok && hw_prot) |=> !write_busy_flag && $stable(pin_protect_enable);
  endproperty
  a_hw_blocks_status: assert property (p_hw_blocks_status) else $error("status write passed hardware protect");

  property p_start_needs_latch;
    array_write_start |-> $past(write_enable_latch) && write_busy_flag;
  endproperty
  a_start_needs_latch: assert property (p_start_needs_latch) else $error("array write without latch");

  property p_start_unprotected;
    array_write_start |-> !is_protected($past(block_code), array_write_addr);
  endproperty
  a_start_unprotected: assert property (p_start_unprotected) else $error("protected block written");

  property p_done_clears_latch;
    $fell(write_busy_flag) |-> !write_enable_latch;
  endproperty
  a_done_clears_latch: assert property (p_done_clears_latch) else $error("latch set after write");

  property p_busy_holds;
    $rose(write_busy_flag) && clk_en && WRITE_CYCLES >= 4 |-> write_busy_flag[*3];
  endproperty
  a_busy_holds: assert property (p_busy_holds) else $error("write cycle cut short");

  property p_busy_ignores;
    (clk_en && frame_end && write_busy_flag) |=>
      !array_write_start && (write_enable_latch == ($past(write_enable_latch) && !$past(prog_done)));
  endproperty
  a_busy_ignores: assert property (p_busy_ignores) else $error("frame acted on while busy");

  property p_unarmed_idle;
    !armed |=> !write_busy_flag && $stable(write_enable_latch);
  endproperty
  a_unarmed_idle: assert property (p_unarmed_idle) else $error("activity before select fall");

  property p_latch_set;
    (go && latch_set_ok) |=> write_enable_latch;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set command lost");

  property p_reserved_zero;
    status_word[6:4] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("unused status bits set");

endmodule

// File: src/eewp_pkg.sv
package eewp_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 10;

  // command opcodes, first byte of every frame
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ARRAY_WRITE_CMD  = 8'h02;
  localparam logic [7:0] LATCH_CLEAR_CMD  = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
  localparam logic [7:0] LATCH_SET_CMD    = 8'h06;

  // status byte layout
  localparam int SR_W                 = 8;
  localparam int SR_PIN_PROTECT_BIT   = 7;
  localparam int SR_BLOCK_HI_BIT      = 3;
  localparam int SR_BLOCK_LO_BIT      = 2;
  localparam int SR_LATCH_BIT         = 1;
  localparam int SR_BUSY_BIT          = 0;

  // frame lengths in serial clock edges
  localparam int                  BIT_CNT_W         = 12;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX       = 12'hfff;
  localparam logic [BIT_CNT_W-1:0] CMD_BITS          = 12'h008;
  localparam logic [BIT_CNT_W-1:0] STATUS_WRITE_BITS = 12'h010;
  localparam logic [BIT_CNT_W-1:0] ADDR_END_BITS     = 12'h018;
  localparam logic [BIT_CNT_W-1:0] MIN_WRITE_BITS    = 12'h020;

  // power-up values; nonvolatile bits start from their erased state
  localparam logic       PIN_PROTECT_RST   = 1'h0;
  localparam logic [1:0] BLOCK_PROTECT_RST = 2'h0;
  localparam logic       LATCH_RST         = 1'h0;

  // block-protect codes
  localparam logic [1:0] PROT_NONE    = 2'h0;
  localparam logic [1:0] PROT_QUARTER = 2'h1;
  localparam logic [1:0] PROT_HALF    = 2'h2;

  typedef enum logic {EEWP_IDLE, EEWP_PROGRAM} eewp_state_t;

endpackage

// File: src/eewp_frame_if.sv
`timescale 1ns/1ps
// words captured during one frame, quasi-static once chip select is high
interface eewp_frame_if;
  logic [7:0]                     op;
  logic [7:0]                     sdata;
  logic [15:0]                    addr;
  logic [eewp_pkg::BIT_CNT_W-1:0] nbits;
  modport link (output op, output sdata, output addr, output nbits);
  modport core (input op, input sdata, input addr, input nbits);
endinterface

// File: src/eewp_link.sv
`timescale 1ns/1ps
module eewp_link (
  input  wire logic                      spi_clk,   // serial clock from the host
  input  wire logic                      rst,       // power-up reset, async high
  input  wire logic                      cs_n,      // chip select, low active
  input  wire logic                      si,        // serial data in
  input  wire logic [eewp_pkg::SR_W-1:0] status_in, // status byte from core domain
  output logic                           so_out,    // serial data out
  output logic                           so_oe,     // high while driving so
  eewp_frame_if.link                     frame      // captured frame words
);
  import eewp_pkg::*;

  logic                 link_clr;
  logic [BIT_CNT_W-1:0] cnt;
  logic [14:0]          sr;
  logic [SR_W-1:0]      stat_meta;
  logic [SR_W-1:0]      stat_sync;

  assign link_clr = rst | cs_n;

  // edge counter restarts per frame; saturation keeps overlong frames from aliasing to a legal length
  always_ff @(posedge spi_clk or posedge link_clr)
  begin
    if (link_clr)
      cnt <= '0;
    else if (cnt != BIT_CNT_MAX)
      cnt <= cnt + 1'b1;
  end

  // frame words survive chip select so the core can sample them after the frame
  always_ff @(posedge spi_clk or posedge rst)
  begin
    if (rst)
    begin
      sr          <= '0;
      frame.op    <= 8'h00;
      frame.sdata <= 8'h00;
      frame.addr  <= 16'h0000;
      frame.nbits <= '0;
    end
    else
    begin
      sr          <= {sr[13:0], si};
      frame.nbits <= (cnt == BIT_CNT_MAX) ? cnt : cnt + 1'b1;
      if (cnt == CMD_BITS - 1'b1)
        frame.op <= {sr[6:0], si};
      if (cnt == STATUS_WRITE_BITS - 1'b1)
        frame.sdata <= {sr[6:0], si};
      if (cnt == ADDR_END_BITS - 1'b1)
        frame.addr <= {sr[14:0], si};
    end
  end

  // status byte crosses in as a slow level; eight edges pass before it is shifted out
  always_ff @(posedge spi_clk or posedge rst)
  begin
    if (rst)
    begin
      stat_meta <= '0;
      stat_sync <= '0;
    end
    else
    begin
      stat_meta <= status_in;
      stat_sync <= stat_meta;
    end
  end

  // status read drives so on falling edges, msb first, repeating; released as chip select rises
  always_ff @(negedge spi_clk or posedge link_clr)
  begin
    if (link_clr)
    begin
      so_oe  <= 1'b0;
      so_out <= 1'b0;
    end
    else if (cnt >= CMD_BITS && frame.op == STATUS_READ_CMD)
    begin
      so_oe  <= 1'b1;
      so_out <= stat_sync[~cnt[2:0]];
    end
    else
    begin
      so_oe  <= 1'b0;
      so_out <= 1'b0;
    end
  end

endmodule

// File: dv/eewp_host.sv
`timescale 1ns/1ps
// host side of the serial link; the serial clock runs only inside frames
module eewp_host (
  output logic      spi_clk, // serial clock to the device
  output logic      cs_n,    // chip select, low active
  output logic      si,      // serial data to the device
  input  wire logic so_out,  // serial data from the device
  input  wire logic so_oe    // device drives so
);
  localparam int HALF_NS = 32; // 64 ns link period

  // idle until the first frame, so the first activity is a chip-select fall
  initial
  begin
    spi_clk = 1'b0;
    cs_n    = 1'b1;
    si      = 1'b0;
  end

  // one frame, msb first; chip select rises right after the last bit
  task automatic xfer(input logic [39:0] bits, input int n, output logic [7:0] rd, output logic oe_seen);
    int k;
    rd      = 8'h00;
    oe_seen = 1'b1;
    cs_n    = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      k  = n - 1 - i;
      si = bits[i];
      #(HALF_NS);
      if (k >= 8 && k < 16)
      begin
        rd[15-k] = so_out;
        oe_seen  = oe_seen & so_oe;
      end
      spi_clk = 1'b1;
      #(HALF_NS);
      spi_clk = 1'b0;
    end
    #(HALF_NS);
    cs_n = 1'b1;
    si   = ~si;  // no pull on the line, so a released line must not keep the last bit
  endtask
endmodule

// File: dv/eewp_top_test.sv
`timescale 1ns/1ps
module eewp_top_test;
  import eewp_pkg::*;
  localparam int ADDR_W   = 10;   // 1k bytes, quarter boundary at 10'h300
  localparam int WRITE_NS = 6000; // 600 cycles, long enough to overlap two frames
  logic              sys_clk, rst, clk_en, wp_n;
  wire logic         spi_clk, cs_n, si;
  logic              so_out, so_oe, latch, busy, ppe, bp_hi, bp_lo, hw_prot, start, oe, exp_ppe;
  logic [7:0]        status, rd;
  logic [1:0]        exp_bp;
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] exp_q[$];
  logic [15:0]       addrs[7];
  int                err_total, comparisons, seed, lim;

  eewp_top #(.ADDR_W(ADDR_W), .WRITE_TIME_NS(WRITE_NS)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .spi_clk(spi_clk), .cs_n(cs_n), .si(si),
    .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .write_enable_latch(latch), .write_busy_flag(busy),
    .pin_protect_enable(ppe), .block_protect_hi(bp_hi), .block_protect_lo(bp_lo),
    .hw_protect_active(hw_prot), .status_word(status), .array_write_start(start),
    .array_write_addr(waddr)
  );

  eewp_host u_host (.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so_out(so_out), .so_oe(so_oe));

  // 100 MHz core clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk16(input logic [15:0] act, input logic [15:0] exp, input string msg);
    comparisons++;
    if (act !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s: got %h want %h", $time, msg, act, exp);
    end
  endtask

  task automatic chk1(input logic act, input logic exp, input string msg);
    chk16({15'h0, act}, {15'h0, exp}, msg);
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // frame, then chip select high long enough for the core to act on it
  task automatic send(input logic [39:0] bits, input int n);
    u_host.xfer(bits, n, rd, oe);
    gap(8);
  endtask

  task automatic latch_set_cmd();
    send({32'h0, LATCH_SET_CMD}, 8);
  endtask

  // bounded wait for the internal write cycle to finish
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 1000)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    gap(2); // status_word lags the flags by one cycle
    chk16(16'(k), 16'(k < 1000 ? k : 0), "write cycle never ended");
  endtask

  // permitted status write: three bits change, latch clears at its end
  task automatic set_status(input logic [7:0] d);
    latch_set_cmd();
    send({24'h0, STATUS_WRITE_CMD, d}, 16);
    wait_idle();
    exp_ppe = d[SR_PIN_PROTECT_BIT];
    exp_bp  = d[SR_BLOCK_HI_BIT:SR_BLOCK_LO_BIT];
    chk16({8'h0, status}, {8'h0, exp_ppe, 3'h0, exp_bp, 2'h0}, "status after write");
    chk16({13'h0, ppe, bp_hi, bp_lo}, {13'h0, exp_ppe, exp_bp}, "protect bits");
  endtask

  // array write with one random data byte; ok says whether it must start
  task automatic wr(input logic [15:0] a, input bit ok);
    if (ok)
      exp_q.push_back(a[ADDR_W-1:0]);
    send({8'h0, ARRAY_WRITE_CMD, a, 8'($random(seed))}, 32);
    if (ok)
    begin
      wait_idle();
      chk1(latch, 1'b0, "latch after array write");
    end
  endtask

  // each write start is matched against the oldest expectation
  always @(negedge sys_clk)
  begin
    if (start === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk16(16'(waddr), 16'hffff, "unexpected array write");
      else
        chk16(16'(waddr), 16'(exp_q.pop_front()), "array write address");
    end
  end

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // cut a hang short; the whole sequence needs well under half of this
  initial
  begin
    #1000000;
    err_total++;
    final_report();
  end

  initial
  begin
    seed        = 72;
    err_total   = 0;
    comparisons = 0;
    rst         = 1'b1;
    clk_en      = 1'b1;
    wp_n        = 1'b1;
    exp_ppe     = 1'b0;
    exp_bp      = 2'h0;
    addrs       = '{16'h0000, 16'h01ff, 16'h0200, 16'h02ff, 16'h0300, 16'h03ff, 16'h0000};
    addrs[6]    = 16'($random(seed)) & 16'h03ff;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    gap(5);
    chk16({8'h0, status}, 16'h0000, "status at power-up");
    chk1(so_oe, 1'b0, "so driven at power-up");
    latch_set_cmd();
    chk1(latch, 1'b1, "latch set");
    send({32'h0, LATCH_CLEAR_CMD}, 8);
    chk1(latch, 1'b0, "latch clear");
    wr(16'h0010, 1'b0);
    // wrong bit counts must not start anything
    latch_set_cmd();
    send({7'h0, ARRAY_WRITE_CMD, 16'h0020, 8'ha5, 1'b1}, 33);
    send({23'h0, STATUS_WRITE_CMD, 8'h8c, 1'b0}, 17);
    chk16({8'h0, status}, 16'h0002, "odd frames ignored");
    // every protect code against both sides of each boundary
    for (int c = 0; c < 4; c++)
    begin
      lim = (c == 0) ? 1024 : (c == 1) ? 768 : (c == 2) ? 512 : 0;
      set_status({1'b0, 3'($random(seed)), 2'(c), 2'($random(seed))});
      foreach (addrs[i])
      begin
        latch_set_cmd();
        wr(addrs[i], addrs[i] < lim);
      end
    end
    set_status(8'h00);
    // accesses during an internal write cycle
    latch_set_cmd();
    exp_q.push_back(10'h100);
    send({8'h0, ARRAY_WRITE_CMD, 16'h0100, 8'h3c}, 32);
    chk1(busy, 1'b1, "busy after write");
    // with the enable low the write timer must not advance, even past a full cycle
    clk_en = 1'b0;
    gap(700);
    chk1(busy, 1'b1, "write cycle frozen by clock enable");
    clk_en = 1'b1;
    send({8'h0, ARRAY_WRITE_CMD, 16'h0180, 8'hc3}, 32);
    send({24'h0, STATUS_READ_CMD, 8'h00}, 16);
    chk16({8'h0, rd}, 16'h0003, "status read while busy");
    chk1(oe, 1'b1, "so driven during read");
    chk1(so_oe, 1'b0, "so released after frame");
    wait_idle();
    chk1(latch, 1'b0, "latch after busy write");
    // hardware protection: pin low has no effect until enabled
    wp_n = 1'b0;
    gap(6);
    chk1(hw_prot, 1'b0, "pin protect without enable");
    set_status(8'h80);
    chk1(hw_prot, 1'b1, "pin protect active");
    latch_set_cmd();
    send({24'h0, STATUS_WRITE_CMD, 8'h0c}, 16);
    wait_idle();
    chk16({8'h0, status}, 16'h0082, "status write blocked by pin");
    wr(16'h03ff, 1'b1);
    wp_n = 1'b1;
    gap(6);
    chk1(hw_prot, 1'b0, "pin protect released");
    set_status(8'h0c);
    chk16(16'(exp_q.size()), 16'h0000, "missing array writes");
    final_report();
  end
endmodule
